// ---- common/dmlcd_map.svh ----
// Register indices, reset values and scan timing of the dot-matrix panel driver.
`ifndef DMLCD_MAP_SVH
`define DMLCD_MAP_SVH

// Register indices; the bus byte address is four times the index.
`define DMLCD_IDX_SUPPLY   16'hff60
`define DMLCD_IDX_DISPLAY  16'hff61
`define DMLCD_IDX_CONTRAST 16'hff62
`define DMLCD_IDX_MEM_LO   16'hf000
`define DMLCD_IDX_MEM_HI   16'hf276
`define DMLCD_MEM_WORDS    632

// Display memory layout: nibble offsets of the three row groups.
`define DMLCD_PAGE1_BASE   10'h100
`define DMLCD_ROW16_BASE   10'h200

// Field positions.
`define DMLCD_BIT_SUPPLY   0
`define DMLCD_BIT_REFSEL   1
`define DMLCD_BIT_DUTYLO   2
`define DMLCD_BIT_DUTYHI   3
`define DMLCD_BIT_PAGE     0
`define DMLCD_BIT_ALLON    1
`define DMLCD_BIT_ALLOFF   2

// Reset values.
`define DMLCD_RST_SUPPLY   1'b0
`define DMLCD_RST_REFSEL   1'b0
`define DMLCD_RST_DUTY     2'h0
`define DMLCD_RST_PAGE     1'b0
`define DMLCD_RST_ALLON    1'b0
`define DMLCD_RST_ALLOFF   1'b1

// Scan timing: oscillator in Hz, frame rate in Hz at sixteen commons.
`define DMLCD_OSC_HZ       32768
`define DMLCD_FRAME_HZ     32
`define DMLCD_TICKS_COM    (`DMLCD_OSC_HZ / (`DMLCD_FRAME_HZ * 16))
`define DMLCD_TICKS_COM8   (2 * `DMLCD_TICKS_COM)

`endif

// ---- common/dmlcd_pkg.sv ----
// Types shared by the dot-matrix panel driver.
package dmlcd_pkg;

  typedef struct packed {
    logic [16:0] com;
    logic [59:0] seg;
  } dmlcd_panel_t;

  typedef struct packed {
    logic [1:0]  oscSync;
    logic        oscPrev;
    logic [6:0]  divCnt;
    logic [4:0]  comIdx;
    logic [16:0] com;
    logic [59:0] seg;
    logic        supplyOn;
    logic        refSel;
    logic [1:0]  duty;
    logic        allOn;
    logic        allOff;
    logic        page;
    logic [3:0]  contrast;
    logic        rdy;
    logic        err;
    logic [31:0] rdata;
  } dmlcd_state_t;

endpackage : dmlcd_pkg

// ---- core/dmlcd_core.sv ----
// Dot-matrix panel driver: APB control, display memory and common scan.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "dmlcd_map.svh"

module dmlcd_core
  import dmlcd_pkg::*;
#(
  parameter bit EXT_LEVELS = 1'b0
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         srst,
  // APB slave.
  input  wire logic [31:0]  paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // Low-speed oscillator pin.
  input  wire logic         lowSpeedOsc,
  // Panel and drive-level generator.
  output dmlcd_panel_t      panel,
  output logic              driveSupplyOn,
  output logic              referenceLevelSelect,
  output logic [3:0]        contrastCode
);

  // Last active common for a duty select value.
  function automatic logic [4:0] lastCom(input logic [1:0] duty);
    if (duty[1]) begin
      lastCom = 5'h07;
    end else if (duty[0]) begin
      lastCom = 5'h0f;
    end else begin
      lastCom = 5'h10;
    end
  endfunction : lastCom

  // True when a register index falls inside the display memory window.
  function automatic logic isMem(input logic [15:0] idx);
    isMem = (idx >= `DMLCD_IDX_MEM_LO) && (idx <= `DMLCD_IDX_MEM_HI);
  endfunction : isMem

  dmlcd_state_t st_q;
  dmlcd_state_t st_d;

  // Contents are left uninitialised on purpose; software clears them.
  logic [3:0] dispMem [`DMLCD_MEM_WORDS];

  logic [15:0] busIdx;
  logic [9:0]  memOff;
  logic        accessDone;
  logic        oscRise;
  logic        comStep;
  logic [6:0]  comTicks;
  logic [9:0]  rowBase;
  logic        rowHalf;
  logic [1:0]  rowBit;
  logic [59:0] rowData;

  assign busIdx     = paddr[17:2];
  assign memOff     = busIdx[9:0];
  assign accessDone = psel && penable && st_q.rdy;
  assign oscRise    = st_q.oscSync[1] && !st_q.oscPrev;
  assign comTicks   = st_q.duty[1] ? 7'(`DMLCD_TICKS_COM8 - 1) : 7'(`DMLCD_TICKS_COM - 1);
  assign comStep    = oscRise && (st_q.divCnt == comTicks);

  // Row addressing: commons 0-7 and 8-15 use two nibbles per segment, 16 uses one.
  always_comb begin
    rowHalf = st_q.comIdx[2];
    rowBit  = st_q.comIdx[1:0];
    if (st_q.comIdx[4]) begin
      rowBase = `DMLCD_ROW16_BASE;
      rowHalf = 1'b0;
      rowBit  = 2'h0;
    end else if (st_q.comIdx[3]) begin
      rowBase = `DMLCD_PAGE1_BASE;
    end else if (st_q.duty[1] && st_q.page) begin
      rowBase = `DMLCD_PAGE1_BASE;
    end else begin
      rowBase = 10'h000;
    end
  end

  genvar s;
  generate
    for (s = 0; s < 60; s++) begin : gSeg
      logic [9:0] segAddr;
      assign segAddr    = rowBase + 10'(2 * s) + {9'h000, rowHalf};
      assign rowData[s] = dispMem[segAddr][rowBit];
    end
  endgenerate

  always_comb begin
    st_d = st_q;
    st_d.oscSync = {st_q.oscSync[0], lowSpeedOsc};
    st_d.oscPrev = st_q.oscSync[1];

    // Common scan from the oscillator divider.
    if (oscRise) begin
      st_d.divCnt = comStep ? 7'h00 : st_q.divCnt + 7'h01;
    end
    if (st_q.comIdx > lastCom(st_q.duty)) begin
      st_d.comIdx = 5'h00;
    end else if (comStep) begin
      st_d.comIdx = (st_q.comIdx == lastCom(st_q.duty)) ? 5'h00 : st_q.comIdx + 5'h01;
    end
    // Without supply the drive levels collapse, so no common is selected.
    st_d.com = st_q.supplyOn ? 17'(17'h00001 << st_q.comIdx) : 17'h00000;
    if (st_q.allOn) begin
      st_d.seg = {60{1'b1}};
    end else if (st_q.allOff) begin
      st_d.seg = 60'h0;
    end else begin
      st_d.seg = rowData;
    end

    // One wait state: read data is captured at the same edge that pready rises.
    st_d.rdy = psel && penable && !st_q.rdy;
    if (psel && penable && !st_q.rdy) begin
      st_d.rdata = 32'h00000000;
      st_d.err   = 1'b0;
      if (isMem(busIdx)) begin
        st_d.rdata = {28'h0000000, dispMem[memOff]};
      end else if (busIdx == `DMLCD_IDX_SUPPLY) begin
        st_d.rdata = {28'h0000000, st_q.duty, st_q.refSel, st_q.supplyOn};
      end else if (busIdx == `DMLCD_IDX_DISPLAY) begin
        st_d.rdata = {29'h0, st_q.allOff, st_q.allOn, st_q.page};
      end else if (busIdx == `DMLCD_IDX_CONTRAST) begin
        st_d.rdata = {28'h0000000, st_q.contrast};
      end else begin
        st_d.err = 1'b1;
      end
    end

    if (accessDone && pwrite) begin
      if (busIdx == `DMLCD_IDX_SUPPLY) begin
        st_d.supplyOn = pwdata[`DMLCD_BIT_SUPPLY];
        st_d.refSel   = pwdata[`DMLCD_BIT_REFSEL];
        st_d.duty     = {pwdata[`DMLCD_BIT_DUTYHI], pwdata[`DMLCD_BIT_DUTYLO]};
      end
      if (busIdx == `DMLCD_IDX_DISPLAY) begin
        st_d.page   = pwdata[`DMLCD_BIT_PAGE];
        st_d.allOn  = pwdata[`DMLCD_BIT_ALLON];
        st_d.allOff = pwdata[`DMLCD_BIT_ALLOFF];
      end
      if (busIdx == `DMLCD_IDX_CONTRAST) begin
        st_d.contrast = pwdata[3:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q          <= '0;
      st_q.supplyOn <= `DMLCD_RST_SUPPLY;
      st_q.refSel   <= `DMLCD_RST_REFSEL;
      st_q.duty     <= `DMLCD_RST_DUTY;
      st_q.page     <= `DMLCD_RST_PAGE;
      st_q.allOn    <= `DMLCD_RST_ALLON;
      st_q.allOff   <= `DMLCD_RST_ALLOFF;
    end else begin
      st_q <= st_d;
    end
  end

  // The memory has no reset and is written only at the completing edge.
  always_ff @(posedge clk) begin
    if (accessDone && pwrite && isMem(busIdx)) begin
      dispMem[memOff] <= pwdata[3:0];
    end
  end

  assign prdata               = st_q.rdata;
  assign pready               = st_q.rdy;
  assign pslverr              = st_q.rdy && st_q.err;
  assign panel.com            = st_q.com;
  assign panel.seg            = st_q.seg;
  assign driveSupplyOn        = st_q.supplyOn;
  assign referenceLevelSelect = st_q.refSel;
  // With external levels the generator ignores contrast, so it is held at zero.
  assign contrastCode         = EXT_LEVELS ? 4'h0 : st_q.contrast;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_supply_gates_com: assert property (!st_q.supplyOn |=> panel.com == 17'h00000)
    else $error("common driven while supply off");
  a_one_common: assert property (st_q.supplyOn |=> $onehot(panel.com))
    else $error("not exactly one common active");
  // The bound is the duty of the previous cycle; a fresh duty write may find the index beyond it.
  a_duty_range: assert property ($stable(st_q.duty) |=> st_q.comIdx <= lastCom($past(st_q.duty)))
    else $error("common index beyond duty");
  a_step_wrap: assert property (comStep && st_q.comIdx == lastCom(st_q.duty) && $stable(st_q.duty)
                                |=> st_q.comIdx == 5'h00)
    else $error("scan did not wrap");
  a_all_on_wins: assert property (st_q.allOn |=> panel.seg == {60{1'b1}})
    else $error("all-on not shown");
  a_all_off: assert property (!st_q.allOn && st_q.allOff |=> panel.seg == 60'h0)
    else $error("all-off not shown");
  a_reset_state: assert property ($past(srst) |-> st_q.allOff && !st_q.supplyOn
                                  && st_q.duty == 2'h0 && !st_q.page && !st_q.refSel)
    else $error("wrong state after reset");
  a_ext_contrast: assert property (EXT_LEVELS |-> contrastCode == 4'h0)
    else $error("contrast active with external levels");
  a_supply_write: assert property (accessDone && pwrite && busIdx == `DMLCD_IDX_SUPPLY
                                   |=> driveSupplyOn == $past(pwdata[0]))
    else $error("supply bit not written");
  a_ready_once: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready not a single pulse");

  c_page_eighth: cover property (st_q.duty[1] && st_q.page && comStep);
  c_both_overrides: cover property (st_q.allOn && st_q.allOff);
  c_mem_write: cover property (accessDone && pwrite && isMem(busIdx));
  c_wrap_seventeen: cover property (comStep && st_q.comIdx == 5'h10);

endmodule : dmlcd_core

// ---- test/dmlcd_core_tb_top.sv ----
// Self-checking bench for the dot-matrix panel driver.
`timescale 1ns/100ps
module dmlcd_core_tb_top;
  import dmlcd_pkg::*;
  logic         clk = 1'b0;
  logic         srst = 1'b1;
  logic [31:0]  paddr = 32'h0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [1:0]   oscDiv = 2'h0;
  logic         clr = 1'b0;
  dmlcd_panel_t panel;
  logic         drvOn;
  logic         refSel;
  logic [3:0]   lc;
  int           maxCom;
  int           frameLen;
  logic         multiCom;
  logic [31:0]  rd;
  logic         err;
  int           fail_count = 0;
  int           cmp_count = 0;

  always #2.5 clk = ~clk;
  // Oscillator runs at a quarter of clk so frames stay short.
  always @(posedge clk) oscDiv <= oscDiv + 2'h1;

  dmlcd_core dut (.clk(clk), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lowSpeedOsc(oscDiv[1]), .panel(panel),
    .driveSupplyOn(drvOn), .referenceLevelSelect(refSel), .contrastCode(lc));
  dmlcd_panel_model pm (.clk(clk), .panel(panel), .clr(clr), .maxCom(maxCom),
    .frameLen(frameLen), .multiCom(multiCom));

  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {14'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 50) begin
      fail_count++;
      results();
    end
  endtask : apb

  task automatic rdc(input logic [15:0] idx, input logic [31:0] e, input string nm);
    apb(1'b0, idx, 32'h0);
    chk(nm, e, rd);
  endtask : rdc

  task automatic waitLvl(input int c, input logic v);
    int n;
    n = 0;
    while (panel.com[c] !== v && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000) begin
      fail_count++;
      results();
    end
  endtask : waitLvl

  task automatic waitCom(input int c);
    waitLvl(c, 1'b0);
    waitLvl(c, 1'b1);
    repeat (3) @(posedge clk);
  endtask : waitCom

  task automatic ovr(input logic [31:0] v, input logic [59:0] e);
    apb(1'b1, 16'hff61, v);
    repeat (2) @(posedge clk);
    chk("allseg", e, panel.seg);
  endtask : ovr

  task automatic t_reset();
    chk("com", 0, panel.com);
    chk("seg", 0, panel.seg);
    chk("supply", 0, drvOn);
    chk("refsel", 0, refSel);
    rdc(16'hff60, 32'h0, "ctrl");
    rdc(16'hff61, 32'h4, "disp");
    apb(1'b0, 16'hff63, 32'h0);
    chk("slverr", 1, err);
  endtask : t_reset

  task automatic t_regs();
    apb(1'b1, 16'hff60, 32'h2);
    chk("refout", 1, refSel);
    repeat (600) @(posedge clk);
    chk("comoff", 0, panel.com);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, 16'hff62, i);
      rdc(16'hff62, i, "lcreg");
      chk("lcout", i, lc);
    end
    apb(1'b1, 16'hff62, 32'h7);
  endtask : t_regs

  task automatic t_mem();
    for (int i = 0; i < 16'h78; i++) begin
      apb(1'b1, 16'hf000 + i[15:0], 32'h0);
      apb(1'b1, 16'hf100 + i[15:0], 32'h0);
    end
    for (int i = 0; i < 60; i++) apb(1'b1, 16'hf200 + 2 * i[15:0], 32'h0);
    apb(1'b1, 16'hf077, 32'hfffffffa);
    rdc(16'hf077, 32'ha, "memrw");
  endtask : t_mem

  task automatic t_dots();
    apb(1'b1, 16'hf000, 32'h1);
    apb(1'b1, 16'hf276, 32'h1);
    apb(1'b1, 16'hf105, 32'h1);
    apb(1'b1, 16'hff61, 32'h0);
    apb(1'b1, 16'hff60, 32'h1);
    chk("supplyon", 1, drvOn);
    waitCom(0);
    chk("seg0", 60'h1, panel.seg);
    waitCom(16);
    chk("seg16", 60'h800000000000000, panel.seg);
    waitCom(12);
    chk("seg12", 60'h4, panel.seg);
    ovr(32'h2, 60'hfffffffffffffff);
    ovr(32'h6, 60'hfffffffffffffff);
    ovr(32'h4, 60'h0);
    apb(1'b1, 16'hff60, 32'h9);
    ovr(32'h1, 60'h0);
    waitCom(4);
    chk("page1", 60'h4, panel.seg);
    ovr(32'h0, 60'h0);
  endtask : t_dots

  task automatic t_duty();
    int mx [4] = '{16, 15, 7, 7};
    int fr [4] = '{4352, 4096, 4096, 4096};
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, 16'hff60, {28'h0, d[1:0], 2'h1});
      waitCom(0);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      waitCom(0);
      chk("lastcom", mx[d], maxCom);
      chk("frame", fr[d], frameLen);
      chk("onehot", 0, multiCom);
    end
  endtask : t_duty

  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_regs();
    t_mem();
    t_dots();
    t_duty();
    results();
  end
endmodule : dmlcd_core_tb_top

// ---- test/dmlcd_panel_model.sv ----
// Panel model: watches the common scan, records frame length and highest common.
`timescale 1ns/100ps
module dmlcd_panel_model
  import dmlcd_pkg::*;
(
  // Clock and panel pins.
  input  wire logic         clk,
  input  wire dmlcd_panel_t panel,
  // Observation control and results.
  input  wire logic         clr,
  output int                maxCom,
  output int                frameLen,
  output logic              multiCom
);
  int   cnt   = 0;
  logic prev0 = 1'b0;

  // A frame is timed from one rise of common 0 to the next.
  always @(posedge clk) begin
    prev0 <= panel.com[0];
    cnt <= (panel.com[0] && !prev0) ? 1 : cnt + 1;
    if (panel.com[0] && !prev0) frameLen <= cnt;
    if ($countones(panel.com) > 1) multiCom <= 1'b1;
    for (int i = 0; i < 17; i++)
      if (panel.com[i] === 1'b1 && i > maxCom) maxCom <= i;
    if (clr) begin
      maxCom <= 0;
      multiCom <= 1'b0;
    end
  end
endmodule : dmlcd_panel_model
